// ### core/adc_link_pkg.sv
// shared constants for the converter target and its bus controller
package adc_link_pkg;
    localparam logic [1:0]  PTR_RESULT      = 2'h0;
    localparam logic [1:0]  PTR_CONFIG      = 2'h1;
    localparam logic [1:0]  PTR_LO_THRESH   = 2'h2;
    localparam logic [1:0]  PTR_HI_THRESH   = 2'h3;
    localparam logic [15:0] CONFIG_RESET    = 16'h8583;
    localparam logic [15:0] RESULT_RESET    = 16'h0000;
    localparam logic [15:0] LO_THRESH_RESET = 16'h8000;
    localparam logic [15:0] HI_THRESH_RESET = 16'h7FFF;
    localparam int          CFG_START_BIT   = 15;
    localparam int          CFG_MODE_BIT    = 8;
    localparam logic [6:0]  TARGET_BASE     = 7'h48;
    localparam logic [6:0]  GENERAL_CALL    = 7'h00;
    localparam logic [7:0]  GC_RESET_CMD    = 8'h06;
    localparam logic [1:0]  SEL_GND         = 2'h0;
    localparam logic [1:0]  SEL_VDD         = 2'h1;
    localparam logic [1:0]  SEL_SCL         = 2'h2;
    localparam logic [1:0]  SEL_SDA         = 2'h3;
    localparam int          CONV_CYCLES     = 64;
    localparam int          SCL_HALF_CYCLES = 8;
endpackage : adc_link_pkg

// ### core/adc_link_if.sv
// open-drain two-wire link between converter target and bus controller
interface adc_link_if;
    logic scl_out;
    logic scl_oe;
    logic sda_ctl_out;
    logic sda_ctl_oe;
    logic sda_tgt_out;
    logic sda_tgt_oe;
    logic scl;
    logic sda;
    assign scl = ~(scl_oe & ~scl_out);
    assign sda = ~((sda_ctl_oe & ~sda_ctl_out) | (sda_tgt_oe & ~sda_tgt_out));
    modport target (input scl, input sda, output sda_tgt_out, output sda_tgt_oe);
    modport controller (input scl, input sda, output scl_out, output scl_oe, output sda_ctl_out, output sda_ctl_oe);
endinterface : adc_link_if

// ### core/adc_target.sv
// converter target: two-wire slave, register file and conversion sequencing
module adc_target
    import adc_link_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    adc_link_if.target       link,
    input  wire logic [1:0]  addr_sel,
    input  wire logic [15:0] sample_in,
    output logic             converting,
    output logic             result_strobe,
    output logic [15:0]      result,
    output logic [15:0]      config_word
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_RECV  = 7'b0000010,
        ST_ACK   = 7'b0000100,
        ST_SEND  = 7'b0001000,
        ST_RACK  = 7'b0010000,
        ST_IGN   = 7'b0100000,
        ST_ACKE  = 7'b1000000
    } bus_state_t;

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic [3:0]  sel_sync;
        logic        scl_prev;
        logic        sda_prev;
        bus_state_t  state;
        logic [2:0]  bit_cnt;
        logic [7:0]  shreg;
        logic [1:0]  byte_idx;
        logic        rd;
        logic        gcall;
        logic        gc_hit;
        logic [1:0]  ptr;
        logic [7:0]  hi_byte;
        logic        sda_low;
        logic [15:0] result;
        logic [15:0] config_word;
        logic [15:0] lo_thresh;
        logic [15:0] hi_thresh;
        logic        converting;
        logic [15:0] conv_cnt;
        logic        result_strobe;
    } state_t;

    state_t cur;
    state_t next_cur;
    logic   [6:0]  own_addr;
    logic   [15:0] rd_word;

    always_comb begin
        own_addr = TARGET_BASE | {5'h00, cur.sel_sync[3:2]};
        case (cur.ptr)
            PTR_RESULT:    rd_word = cur.result;
            PTR_CONFIG:    rd_word = {cur.converting ? 1'b0 : 1'b1, cur.config_word[14:0]};
            PTR_LO_THRESH: rd_word = cur.lo_thresh;
            default:       rd_word = cur.hi_thresh;
        endcase
    end

    always_comb begin
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic start_c;
        logic stop_c;
        logic [7:0] byte_v;
        scl = cur.scl_sync[1];
        sda = cur.sda_sync[1];
        next_cur = cur;
        next_cur.scl_sync = {cur.scl_sync[0], link.scl};
        next_cur.sda_sync = {cur.sda_sync[0], link.sda};
        next_cur.scl_prev = scl;
        next_cur.sda_prev = sda;
        next_cur.sel_sync = {cur.sel_sync[1:0], addr_sel};
        next_cur.result_strobe = 1'b0;
        rise = scl & ~cur.scl_prev;
        fall = ~scl & cur.scl_prev;
        start_c = scl & cur.scl_prev & cur.sda_prev & ~sda;
        stop_c = scl & cur.scl_prev & ~cur.sda_prev & sda;
        byte_v = {cur.shreg[6:0], sda};

        // conversion sequencing, always active even with bus traffic
        if (cur.converting) begin
            if (cur.conv_cnt == 16'(CONV_CYCLES - 1)) begin
                next_cur.result = sample_in;
                next_cur.result_strobe = 1'b1;
                next_cur.conv_cnt = 16'h0000;
                next_cur.converting = ~cur.config_word[CFG_MODE_BIT];
            end else begin
                next_cur.conv_cnt = cur.conv_cnt + 16'h0001;
            end
        end else if (!cur.config_word[CFG_MODE_BIT]) begin
            next_cur.converting = 1'b1;
        end

        if (start_c) begin
            next_cur.state = ST_RECV;
            next_cur.bit_cnt = 3'h0;
            next_cur.byte_idx = 2'h0;
            next_cur.sda_low = 1'b0;
        end else if (stop_c) begin
            next_cur.state = ST_IDLE;
            next_cur.sda_low = 1'b0;
        end else begin
            case (cur.state)
                ST_RECV: if (rise) begin
                    next_cur.shreg = byte_v;
                    next_cur.bit_cnt = cur.bit_cnt + 3'h1;
                    if (cur.bit_cnt == 3'h7) begin
                        next_cur.state = ST_ACKE;
                        if (cur.byte_idx == 2'h0) begin
                            next_cur.rd = byte_v[0];
                            next_cur.gcall = (byte_v[7:1] == GENERAL_CALL) & ~byte_v[0];
                            if (byte_v[7:1] != own_addr && !((byte_v[7:1] == GENERAL_CALL) && !byte_v[0]))
                                next_cur.state = ST_IGN;
                        end else if (cur.gcall) begin
                            next_cur.gc_hit = (byte_v == GC_RESET_CMD);
                        end else if (cur.byte_idx == 2'h1) begin
                            next_cur.ptr = byte_v[1:0];
                        end else if (cur.byte_idx == 2'h2) begin
                            next_cur.hi_byte = byte_v;
                        end else if (cur.byte_idx == 2'h3) begin
                            case (cur.ptr)
                                PTR_CONFIG: begin
                                    next_cur.config_word = {cur.hi_byte, byte_v};
                                    next_cur.config_word[CFG_START_BIT] = 1'b0;
                                    if (cur.hi_byte[7] && !cur.converting && cur.hi_byte[0])
                                        next_cur.converting = 1'b1;
                                    if (cur.hi_byte[0])
                                        next_cur.conv_cnt = cur.converting ? next_cur.conv_cnt : 16'h0000;
                                end
                                PTR_LO_THRESH: next_cur.lo_thresh = {cur.hi_byte, byte_v};
                                PTR_HI_THRESH: next_cur.hi_thresh = {cur.hi_byte, byte_v};
                                default: ;
                            endcase
                        end
                    end
                end
                ST_ACKE: if (fall) begin
                    next_cur.sda_low = 1'b1;
                    next_cur.state = ST_ACK;
                end
                ST_ACK: if (fall) begin
                    next_cur.sda_low = 1'b0;
                    next_cur.bit_cnt = 3'h0;
                    if (cur.byte_idx != 2'h3)
                        next_cur.byte_idx = cur.byte_idx + 2'h1;
                    if (cur.gc_hit) begin
                        next_cur = '0;
                        next_cur.scl_sync = {cur.scl_sync[0], link.scl};
                        next_cur.sda_sync = {cur.sda_sync[0], link.sda};
                        next_cur.scl_prev = scl;
                        next_cur.sda_prev = sda;
                        next_cur.sel_sync = {cur.sel_sync[1:0], addr_sel};
                        next_cur.state = ST_IGN;
                        next_cur.config_word = CONFIG_RESET;
                        next_cur.result = RESULT_RESET;
                        next_cur.lo_thresh = LO_THRESH_RESET;
                        next_cur.hi_thresh = HI_THRESH_RESET;
                    end else if (cur.rd && cur.byte_idx == 2'h0) begin
                        next_cur.state = ST_SEND;
                        next_cur.shreg = rd_word[15:8];
                        next_cur.hi_byte = rd_word[7:0];
                        next_cur.sda_low = ~rd_word[15];
                    end else begin
                        next_cur.state = ST_RECV;
                    end
                end
                ST_SEND: if (fall) begin
                    next_cur.bit_cnt = cur.bit_cnt + 3'h1;
                    next_cur.shreg = {cur.shreg[6:0], 1'b0};
                    next_cur.sda_low = (cur.bit_cnt == 3'h7) ? 1'b0 : ~cur.shreg[6];
                    if (cur.bit_cnt == 3'h7)
                        next_cur.state = ST_RACK;
                end
                ST_RACK: if (rise) begin
                    if (sda) begin
                        next_cur.state = ST_IGN;
                    end else begin
                        next_cur.shreg = cur.hi_byte;
                        next_cur.hi_byte = 8'hFF;
                        next_cur.bit_cnt = 3'h0;
                        // stay until the fall, which drives the low byte's top bit
                        next_cur.sda_low = 1'b0;
                    end
                end else if (fall) begin
                    next_cur.sda_low = ~cur.shreg[7];
                end
                default: ;
            endcase
        end
        if (cur.state == ST_RACK && !rise && fall && !start_c && !stop_c)
            next_cur.state = ST_SEND;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.scl_sync <= 2'h3;
            cur.sda_sync <= 2'h3;
            cur.scl_prev <= 1'b1;
            cur.sda_prev <= 1'b1;
            cur.state <= ST_IDLE;
            cur.config_word <= CONFIG_RESET;
            cur.result <= RESULT_RESET;
            cur.lo_thresh <= LO_THRESH_RESET;
            cur.hi_thresh <= HI_THRESH_RESET;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign link.sda_tgt_out = 1'b0;
    assign link.sda_tgt_oe = cur.sda_low;
    assign converting = cur.converting;
    assign result_strobe = cur.result_strobe;
    assign result = cur.result;
    assign config_word = cur.config_word;
endmodule : adc_target

// ### core/adc_controller.sv
// bus controller end: runs one write or read transfer per request
module adc_controller
    import adc_link_pkg::*;
#(
    parameter int HALF = SCL_HALF_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    adc_link_if.controller   link,
    input  wire logic        req,
    input  wire logic        req_read,
    input  wire logic [1:0]  req_nbytes,
    input  wire logic [6:0]  req_addr,
    input  wire logic [7:0]  req_ptr,
    input  wire logic [15:0] req_data,
    output logic             busy,
    output logic             done,
    output logic             nacked,
    output logic [15:0]      rd_data
);
    typedef enum logic [4:0] {
        C_IDLE  = 5'b00001,
        C_START = 5'b00010,
        C_BIT   = 5'b00100,
        C_STOP  = 5'b01000,
        C_END   = 5'b10000
    } ctl_state_t;

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        ctl_state_t  state;
        logic [7:0]  div;
        logic [1:0]  phase;
        logic [3:0]  bit_cnt;
        logic [1:0]  byte_idx;
        logic [1:0]  nbytes;
        logic [31:0] txbuf;
        logic        rd;
        logic        scl_low;
        logic        sda_low;
        logic        busy;
        logic        done;
        logic        nacked;
        logic [15:0] rd_data;
    } cstate_t;

    cstate_t cur;
    cstate_t next_cur;

    always_comb begin
        logic tick;
        logic last_byte;
        logic ack_bit;
        next_cur = cur;
        next_cur.scl_sync = {cur.scl_sync[0], link.scl};
        next_cur.sda_sync = {cur.sda_sync[0], link.sda};
        next_cur.done = 1'b0;
        tick = (cur.div == 8'(HALF - 1));
        next_cur.div = tick ? 8'h00 : cur.div + 8'h01;
        last_byte = (cur.byte_idx == cur.nbytes);
        ack_bit = cur.bit_cnt == 4'h8;
        case (cur.state)
            C_IDLE: begin
                next_cur.div = 8'h00;
                if (req && cur.scl_sync[1] && cur.sda_sync[1]) begin
                    next_cur.state = C_START;
                    next_cur.busy = 1'b1;
                    next_cur.nacked = 1'b0;
                    next_cur.rd = req_read;
                    next_cur.nbytes = req_nbytes;
                    next_cur.txbuf = {req_addr, req_read, req_ptr, req_data};
                    next_cur.sda_low = 1'b1;
                end
            end
            C_START: if (tick) begin
                next_cur.scl_low = 1'b1;
                next_cur.state = C_BIT;
                next_cur.phase = 2'h0;
                next_cur.bit_cnt = 4'h0;
                next_cur.byte_idx = 2'h0;
            end
            C_BIT: if (tick) begin
                next_cur.phase = cur.phase + 2'h1;
                case (cur.phase)
                    2'h0: begin
                        if (ack_bit)
                            next_cur.sda_low = cur.rd && cur.byte_idx != 2'h0 && !last_byte;
                        else if (cur.rd && cur.byte_idx != 2'h0)
                            next_cur.sda_low = 1'b0;
                        else
                            next_cur.sda_low = ~cur.txbuf[31];
                    end
                    2'h1: next_cur.scl_low = 1'b0;
                    2'h2: begin
                        if (ack_bit) begin
                            if (!(cur.rd && cur.byte_idx != 2'h0) && cur.sda_sync[1])
                                next_cur.nacked = 1'b1;
                        end else if (cur.rd && cur.byte_idx != 2'h0) begin
                            next_cur.rd_data = {cur.rd_data[14:0], cur.sda_sync[1]};
                        end else begin
                            next_cur.txbuf = {cur.txbuf[30:0], 1'b0};
                        end
                    end
                    default: begin
                        next_cur.scl_low = 1'b1;
                        next_cur.bit_cnt = ack_bit ? 4'h0 : cur.bit_cnt + 4'h1;
                        if (ack_bit) begin
                            next_cur.byte_idx = cur.byte_idx + 2'h1;
                            if (last_byte || cur.nacked)
                                next_cur.state = C_STOP;
                        end
                    end
                endcase
            end
            C_STOP: if (tick) begin
                next_cur.phase = cur.phase + 2'h1;
                case (cur.phase)
                    2'h0: next_cur.sda_low = 1'b1;
                    2'h1: next_cur.scl_low = 1'b0;
                    2'h2: next_cur.sda_low = 1'b0;
                    default: next_cur.state = C_END;
                endcase
            end
            default: begin
                next_cur.state = C_IDLE;
                next_cur.busy = 1'b0;
                next_cur.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.scl_sync <= 2'h3;
            cur.sda_sync <= 2'h3;
            cur.state <= C_IDLE;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign link.scl_out = 1'b0;
    assign link.scl_oe = cur.scl_low;
    assign link.sda_ctl_out = 1'b0;
    assign link.sda_ctl_oe = cur.sda_low;
    assign busy = cur.busy;
    assign done = cur.done;
    assign nacked = cur.nacked;
    assign rd_data = cur.rd_data;
endmodule : adc_controller

// ### tb/adc_link_assertions.sv
// assertions on the two-wire link between target and controller
module adc_link_assertions (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic scl_oe,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_ctl_oe,
    input wire logic sda_tgt_oe,
    input wire logic sda_tgt_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       scl_q;
    logic       sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] idle_cnt;
    wire        start    = scl & scl_q & sda_q & ~sda;
    wire        stop     = scl & scl_q & ~sda_q & sda;
    wire        scl_rise = scl & ~scl_q;
    // bit count since start and cycles of idle bus
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            bit_cnt  <= 4'hF;
            idle_cnt <= 8'h00;
        end else begin
            scl_q    <= scl;
            sda_q    <= sda;
            if (start)
                bit_cnt <= 4'h0;
            else if (scl_rise && bit_cnt != 4'hF)
                bit_cnt <= bit_cnt + 4'h1;
            if (!(scl && sda))
                idle_cnt <= 8'h00;
            else if (idle_cnt != 8'hFF)
                idle_cnt <= idle_cnt + 8'h1;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    a_no_clock_drive: assert property (!scl_oe |-> scl)
        else $error("clock line low with no controller drive");
    a_tgt_pulls_low: assert property (sda_tgt_oe |-> (!sda && sda_tgt_out == 1'b0))
        else $error("target drive does not pull data low");
    a_tgt_stable_high: assert property ((scl && scl_q) |-> $stable(sda_tgt_oe))
        else $error("target data changed while clock high");
    a_addr_byte_quiet: assert property ((scl_rise && bit_cnt < 4'h8) |-> !sda_tgt_oe)
        else $error("target drove data during address byte");
    a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low period too short");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high period too short");
    a_start_then_low: assert property (start |-> ##[1:40] !scl)
        else $error("no clock low after start");
    a_stop_releases: assert property (stop |-> !sda_tgt_oe [*8])
        else $error("target drives data after stop");
    a_start_from_idle: assert property (start |-> idle_cnt >= 8'h02)
        else $error("start on a busy bus");
    a_ctl_edge_cond: assert property ((scl && scl_q && $changed(sda_ctl_oe)) |-> (start || stop))
        else $error("controller data changed while clock high");
endmodule : adc_link_assertions

// ### tb/tb.sv
// testbench: target and controller joined over the link
module tb;
    import adc_link_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk;
    logic        rst;
    logic        clk_en;
    logic [1:0]  addr_sel;
    logic [15:0] sample_in;
    logic        req;
    logic        req_read;
    logic [1:0]  req_nbytes;
    logic [6:0]  req_addr;
    logic [7:0]  req_ptr;
    logic [15:0] req_data;
    logic        converting;
    logic        result_strobe;
    logic [15:0] result;
    logic [15:0] config_word;
    logic        busy;
    logic        done;
    logic        nacked;
    logic [15:0] rd_data;
    logic [36:0] mon;
    logic [15:0] v;
    logic [15:0] samp;
    logic [6:0]  a;
    int          n_fail;
    int          n_checks;
    int          n_strobe;
    int          n0;
    int          seed;
    int          i;

    adc_link_if link ();
    adc_target i_adc_target (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link(link), .addr_sel(addr_sel),
        .sample_in(sample_in), .converting(converting), .result_strobe(result_strobe), .result(result),
        .config_word(config_word));
    adc_controller i_adc_controller (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .link(link), .req(req),
        .req_read(req_read), .req_nbytes(req_nbytes), .req_addr(req_addr), .req_ptr(req_ptr), .req_data(req_data),
        .busy(busy), .done(done), .nacked(nacked), .rd_data(rd_data));
    adc_link_assertions i_adc_link_assertions (.core_clk(core_clk), .rst(rst), .scl_oe(link.scl_oe),
        .scl(link.scl), .sda(link.sda), .sda_ctl_oe(link.sda_ctl_oe), .sda_tgt_oe(link.sda_tgt_oe),
        .sda_tgt_out(link.sda_tgt_out));

    function automatic logic [15:0] reset_val(input logic [1:0] p);
        return (p == PTR_RESULT) ? RESULT_RESET : (p == PTR_CONFIG) ? CONFIG_RESET :
               (p == PTR_LO_THRESH) ? LO_THRESH_RESET : HI_THRESH_RESET;
    endfunction : reset_val
    function automatic logic [6:0] sel_addr(input logic [1:0] s);
        return TARGET_BASE + {5'h00, s};
    endfunction : sel_addr

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic rd, input logic [1:0] nb, input logic [6:0] ad, input logic [7:0] p,
                        input logic [15:0] d);
        int k;
        @(posedge core_clk);
        req        <= 1'b1;
        req_read   <= rd;
        req_nbytes <= nb;
        req_addr   <= ad;
        req_ptr    <= p;
        req_data   <= d;
        for (k = 0; k < 100 && busy !== 1'b1; k++) @(negedge core_clk);
        @(posedge core_clk);
        req <= 1'b0;
        for (k = 0; k < 5000 && done !== 1'b1; k++) @(negedge core_clk);
        @(negedge core_clk);
    endtask : xfer
    task automatic rd_reg(input logic [1:0] p);
        xfer(1'b0, 2'h1, a, {6'h00, p}, 16'h0000);
        xfer(1'b1, 2'h2, a, 8'h00, 16'h0000);
    endtask : rd_reg
    task automatic expect_quiet();
        repeat (CONV_CYCLES * 2) @(negedge core_clk);
        n0 = n_strobe;
        repeat (CONV_CYCLES * 4) @(negedge core_clk);
        chk(16'(n_strobe - n0), 16'h0000);
    endtask : expect_quiet
    task automatic end_of_test();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(negedge core_clk) if (result_strobe === 1'b1) n_strobe++;
    always @(posedge link.scl) mon <= {mon[35:0], link.sda};
    initial begin
        #(60000 * 100);
        n_fail++;
        end_of_test();
    end

    initial begin
        seed = 32'hb586;
        {rst, clk_en, addr_sel, sample_in} = {1'b1, 1'b1, SEL_GND, 16'h0000};
        {req, req_read, req_nbytes, req_addr, req_ptr, req_data} = '0;
        {n_fail, n_checks, n_strobe, mon} = '0;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (3) @(posedge core_clk);
        a = sel_addr(SEL_GND);
        chk({15'h0000, converting}, 16'h0000);
        for (i = 0; i < 4; i++) begin
            rd_reg(i[1:0]);
            chk(rd_data, reset_val(i[1:0]));
        end
        xfer(1'b1, 2'h2, a, 8'h00, 16'h0000);
        chk(rd_data, HI_THRESH_RESET);
        for (i = 2; i < 4; i++) begin
            v = 16'($random(seed));
            xfer(1'b0, 2'h3, a, {6'h00, i[1:0]}, v);
            chk({mon[18:11], mon[9:2]}, v);
            chk({12'h000, mon[28], mon[19], mon[10], mon[1]}, 16'h0000);
            chk({8'h00, mon[36:29]}, {8'h00, a, 1'b0});
            chk({15'h0000, mon[0]}, 16'h0000);
            xfer(1'b1, 2'h2, a, 8'h00, 16'h0000);
            chk(rd_data, v);
        end
        for (i = 0; i < 4; i++) begin
            @(posedge core_clk);
            addr_sel <= i[1:0];
            xfer(1'b0, 2'h3, sel_addr(i[1:0] + 2'h1), {6'h00, PTR_HI_THRESH}, ~v);
            chk({15'h0000, nacked}, 16'h0001);
            xfer(1'b1, 2'h2, sel_addr(i[1:0]), 8'h00, 16'h0000);
            chk({15'h0000, nacked}, 16'h0000);
            chk(rd_data, v);
        end
        @(posedge core_clk);
        addr_sel  <= SEL_GND;
        samp = 16'($random(seed));
        sample_in <= samp;
        n0 = n_strobe;
        xfer(1'b0, 2'h3, a, {6'h00, PTR_CONFIG}, CONFIG_RESET);
        repeat (CONV_CYCLES * 2) @(negedge core_clk);
        chk(result, samp);
        chk({15'h0000, converting}, 16'h0000);
        rd_reg(PTR_RESULT);
        chk(rd_data, samp);
        rd_reg(PTR_CONFIG);
        chk(rd_data, CONFIG_RESET);
        chk(16'(n_strobe - n0), 16'h0001);
        @(posedge core_clk);
        samp = 16'($random(seed));
        sample_in <= samp;
        xfer(1'b0, 2'h3, a, {6'h00, PTR_CONFIG}, 16'h0483);
        chk({1'b0, config_word[14:0]}, 16'h0483);
        n0 = n_strobe;
        repeat (CONV_CYCLES * 6) @(negedge core_clk);
        chk({15'h0000, 1'(n_strobe - n0 inside {5, 6})}, 16'h0001);
        chk(result, samp);
        xfer(1'b0, 2'h3, a, {6'h00, PTR_CONFIG}, 16'h0583);
        expect_quiet();
        xfer(1'b0, 2'h3, a, {6'h00, PTR_CONFIG}, 16'h0483);
        xfer(1'b0, 2'h1, GENERAL_CALL, GC_RESET_CMD, 16'h0000);
        chk({15'h0000, nacked}, 16'h0000);
        chk(config_word, CONFIG_RESET);
        expect_quiet();
        rd_reg(PTR_HI_THRESH);
        chk(rd_data, HI_THRESH_RESET);
        end_of_test();
    end
endmodule : tb
